//--- rtl/sta_pkg.sv
// package for the two-thread pipeline arbiter
// assumes a single core clock and two logical processors
package sta_pkg;

    // ----------------------------------------
    // sizes
    // ----------------------------------------
    localparam int unsigned STA_DISPATCH_MAX = 6;
    localparam int unsigned STA_UOPQ_DEPTH   = 16;
    localparam int unsigned STA_ROB_DEPTH    = 32;
    localparam int unsigned STA_RNQ_DEPTH    = 16;
    localparam int unsigned STA_LDB_DEPTH    = 16;
    localparam int unsigned STA_STB_DEPTH    = 8;
    localparam int unsigned STA_CNT_W        = 6;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic STA_PRIO_RST = 1'b0;

    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [1:0] {
        STA_SEL_NONE = 2'b00,
        STA_SEL_T0   = 2'b01,
        STA_SEL_T1   = 2'b10
    } sta_sel_t;

    typedef struct packed {
        logic t0;
        logic t1;
    } sta_pair_t;

    typedef struct packed {
        logic [STA_CNT_W-1:0] t0;
        logic [STA_CNT_W-1:0] t1;
    } sta_occ_t;

endpackage

//--- rtl/sta_alt_sel.sv
// alternating two-way selector with per-cycle arbitration
// assumes requests from logic on the same clock
`timescale 1ns/100ps
`default_nettype none
module sta_alt_sel
    import sta_pkg::*;
(
    // clock and reset
    input  wire logic      core_clk_i,
    input  wire logic      reset_n_i,
    input  wire logic      clk_en_i,
    // requests and grant
    input  var  sta_pair_t req_i,
    output var  sta_pair_t gnt_o,
    output logic           prio_o
);

    logic prio_q;
    logic both;

    assign both    = req_i.t0 & req_i.t1;
    assign gnt_o.t0 = req_i.t0 & (~req_i.t1 | ~prio_q);
    assign gnt_o.t1 = req_i.t1 & (~req_i.t0 | prio_q);
    assign prio_o   = prio_q;

    // ----------------------------------------
    // priority flip
    // ----------------------------------------
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            prio_q <= STA_PRIO_RST;
        end else if (clk_en_i && both) begin
            prio_q <= ~prio_q;
        end
    end

    chk_alt_both_toggle: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        clk_en_i && both && gnt_o.t0 ##1 clk_en_i && both |-> gnt_o.t1)
        else $error("alternation lost");

    chk_alt_solo_full: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        req_i.t1 && !req_i.t0 |-> gnt_o.t1 && !gnt_o.t0)
        else $error("solo requester not granted");

endmodule
`default_nettype wire

//--- rtl/sta_arbiter.sv
// top of the two-thread pipeline arbiter
// assumes all stage inputs come from logic on core_clk_i
`timescale 1ns/100ps
`default_nettype none
module sta_arbiter
    import sta_pkg::*;
(
    // clock and reset
    input  wire logic                  core_clk_i,
    input  wire logic                  reset_n_i,
    input  wire logic                  clk_en_i,
    // thread activity
    input  var  sta_pair_t             active_i,
    // trace cache fetch
    input  var  sta_pair_t             fetch_req_i,
    input  var  sta_pair_t             fetch_miss_i,
    input  var  sta_pair_t             fetch_fill_i,
    output var  sta_pair_t             fetch_gnt_o,
    // micro-op queue
    input  var  sta_pair_t             uopq_push_i,
    input  var  sta_pair_t             uopq_pop_i,
    output var  sta_pair_t             uopq_ready_o,
    output var  sta_occ_t              uopq_occ_o,
    // rename queue, load and store buffers
    input  var  sta_pair_t             rnq_push_i,
    input  var  sta_pair_t             rnq_pop_i,
    output var  sta_pair_t             rnq_ready_o,
    input  var  sta_pair_t             ldb_push_i,
    input  var  sta_pair_t             ldb_pop_i,
    output var  sta_pair_t             ldb_ready_o,
    input  var  sta_pair_t             stb_push_i,
    input  var  sta_pair_t             stb_pop_i,
    output var  sta_pair_t             stb_ready_o,
    // dispatch
    input  wire logic [15:0]           wait_ready_i,
    output logic [15:0]                dispatch_o,
    output logic [2:0]                 dispatch_cnt_o,
    // reorder buffer and retirement
    input  var  sta_pair_t             rob_push_i,
    output var  sta_pair_t             rob_ready_o,
    output var  sta_occ_t              rob_occ_o,
    input  var  sta_pair_t             retire_rdy_i,
    output var  sta_pair_t             retire_gnt_o,
    // store commit
    input  var  sta_pair_t             commit_req_i,
    output var  sta_pair_t             commit_gnt_o
);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [STA_CNT_W-1:0] occ_next(
        input logic [STA_CNT_W-1:0] cur,
        input logic                 push,
        input logic                 pop
    );
        logic [STA_CNT_W-1:0] r;
        r = cur;
        if (push && !pop) begin
            r = cur + 1'b1;
        end else if (pop && !push && cur != '0) begin
            r = cur - 1'b1;
        end
        return r;
    endfunction

    function automatic logic [STA_CNT_W-1:0] half_of(input int unsigned depth);
        return STA_CNT_W'(depth / 2);
    endfunction

    // ----------------------------------------
    // trace cache fetch
    // ----------------------------------------
    sta_pair_t stall_q;
    sta_pair_t fetch_eff;
    logic      fetch_prio;

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            stall_q <= '0;
        end else if (clk_en_i) begin
            // miss sets, fill clears; a fill returns the thread
            stall_q.t0 <= (stall_q.t0 | fetch_miss_i.t0) & ~fetch_fill_i.t0;
            stall_q.t1 <= (stall_q.t1 | fetch_miss_i.t1) & ~fetch_fill_i.t1;
        end
    end

    assign fetch_eff.t0 = fetch_req_i.t0 & ~stall_q.t0;
    assign fetch_eff.t1 = fetch_req_i.t1 & ~stall_q.t1;

    sta_alt_sel u_fetch_sel (
        .core_clk_i (core_clk_i),
        .reset_n_i  (reset_n_i),
        .clk_en_i   (clk_en_i),
        .req_i      (fetch_eff),
        .gnt_o      (fetch_gnt_o),
        .prio_o     (fetch_prio)
    );

    // ----------------------------------------
    // partitioned queues
    // ----------------------------------------
    sta_occ_t uopq_q;
    sta_occ_t rnq_q;
    sta_occ_t ldb_q;
    sta_occ_t stb_q;
    sta_occ_t rob_q;
    logic [STA_CNT_W-1:0] uopq_lim;

    // whole queue to a lone active thread, half when both run
    assign uopq_lim = (active_i.t0 & active_i.t1) ? half_of(STA_UOPQ_DEPTH)
                                                  : STA_CNT_W'(STA_UOPQ_DEPTH);

    assign uopq_ready_o.t0 = (uopq_q.t0 < uopq_lim) & ((uopq_q.t0 + uopq_q.t1) < STA_CNT_W'(STA_UOPQ_DEPTH));
    assign uopq_ready_o.t1 = (uopq_q.t1 < uopq_lim) & ((uopq_q.t0 + uopq_q.t1) < STA_CNT_W'(STA_UOPQ_DEPTH));
    assign rnq_ready_o.t0  = rnq_q.t0 < half_of(STA_RNQ_DEPTH);
    assign rnq_ready_o.t1  = rnq_q.t1 < half_of(STA_RNQ_DEPTH);
    assign ldb_ready_o.t0  = ldb_q.t0 < half_of(STA_LDB_DEPTH);
    assign ldb_ready_o.t1  = ldb_q.t1 < half_of(STA_LDB_DEPTH);
    assign stb_ready_o.t0  = stb_q.t0 < half_of(STA_STB_DEPTH);
    assign stb_ready_o.t1  = stb_q.t1 < half_of(STA_STB_DEPTH);
    assign rob_ready_o.t0  = rob_q.t0 < half_of(STA_ROB_DEPTH);
    assign rob_ready_o.t1  = rob_q.t1 < half_of(STA_ROB_DEPTH);
    assign uopq_occ_o      = uopq_q;
    assign rob_occ_o       = rob_q;

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            uopq_q <= '0;
            rnq_q  <= '0;
            ldb_q  <= '0;
            stb_q  <= '0;
            rob_q  <= '0;
        end else if (clk_en_i) begin
            // refused pushes are dropped for that thread only
            uopq_q.t0 <= occ_next(uopq_q.t0, uopq_push_i.t0 & uopq_ready_o.t0, uopq_pop_i.t0);
            uopq_q.t1 <= occ_next(uopq_q.t1, uopq_push_i.t1 & uopq_ready_o.t1, uopq_pop_i.t1);
            rnq_q.t0  <= occ_next(rnq_q.t0, rnq_push_i.t0 & rnq_ready_o.t0, rnq_pop_i.t0);
            rnq_q.t1  <= occ_next(rnq_q.t1, rnq_push_i.t1 & rnq_ready_o.t1, rnq_pop_i.t1);
            ldb_q.t0  <= occ_next(ldb_q.t0, ldb_push_i.t0 & ldb_ready_o.t0, ldb_pop_i.t0);
            ldb_q.t1  <= occ_next(ldb_q.t1, ldb_push_i.t1 & ldb_ready_o.t1, ldb_pop_i.t1);
            stb_q.t0  <= occ_next(stb_q.t0, stb_push_i.t0 & stb_ready_o.t0, stb_pop_i.t0);
            stb_q.t1  <= occ_next(stb_q.t1, stb_push_i.t1 & stb_ready_o.t1, stb_pop_i.t1);
            // retirement frees reorder entries
            rob_q.t0  <= occ_next(rob_q.t0, rob_push_i.t0 & rob_ready_o.t0, retire_gnt_o.t0);
            rob_q.t1  <= occ_next(rob_q.t1, rob_push_i.t1 & rob_ready_o.t1, retire_gnt_o.t1);
        end
    end

    // ----------------------------------------
    // dispatch
    // ----------------------------------------
    always_comb begin
        logic [2:0] n;
        n = '0;
        dispatch_o = '0;
        // lowest slots first, no thread tag looked at
        for (int i = 0; i < 16; i++) begin
            if (wait_ready_i[i] && n < 3'(STA_DISPATCH_MAX)) begin
                dispatch_o[i] = 1'b1;
                n = n + 3'd1;
            end
        end
        dispatch_cnt_o = n;
    end

    // ----------------------------------------
    // retirement and store commit
    // ----------------------------------------
    sta_pair_t retire_req;
    logic      retire_prio;
    logic      commit_prio;

    assign retire_req.t0 = retire_rdy_i.t0 & (rob_q.t0 != '0);
    assign retire_req.t1 = retire_rdy_i.t1 & (rob_q.t1 != '0);

    // one head per thread, so program order holds
    sta_alt_sel u_retire_sel (
        .core_clk_i (core_clk_i),
        .reset_n_i  (reset_n_i),
        .clk_en_i   (clk_en_i),
        .req_i      (retire_req),
        .gnt_o      (retire_gnt_o),
        .prio_o     (retire_prio)
    );

    sta_alt_sel u_commit_sel (
        .core_clk_i (core_clk_i),
        .reset_n_i  (reset_n_i),
        .clk_en_i   (clk_en_i),
        .req_i      (commit_req_i),
        .gnt_o      (commit_gnt_o),
        .prio_o     (commit_prio)
    );

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence s_t0_miss;
        clk_en_i && fetch_miss_i.t0 && !fetch_fill_i.t0;
    endsequence

    chk_fetch_stall_hold: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        s_t0_miss ##1 (!fetch_fill_i.t0 && fetch_req_i.t1) |-> fetch_gnt_o.t1 && !fetch_gnt_o.t0)
        else $error("stalled thread took fetch slot");

    chk_dispatch_max_six: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        $countones(dispatch_o) <= STA_DISPATCH_MAX && (dispatch_o & ~wait_ready_i) == '0)
        else $error("dispatch too wide or not ready");

    chk_dispatch_fill_up: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        $countones(wait_ready_i) >= STA_DISPATCH_MAX |-> dispatch_cnt_o == 3'(STA_DISPATCH_MAX))
        else $error("ready uops left undispatched");

    chk_rob_half_cap: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        rob_q.t0 <= half_of(STA_ROB_DEPTH) && rob_q.t1 <= half_of(STA_ROB_DEPTH))
        else $error("reorder share exceeded");

    chk_retire_alt_both: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        clk_en_i && retire_req.t0 && retire_req.t1 && retire_gnt_o.t0 ##1
        clk_en_i && retire_req.t0 && retire_req.t1 |-> retire_gnt_o.t1)
        else $error("retirement did not alternate");

    chk_retire_solo_full: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        retire_req.t0 && !retire_req.t1 |-> retire_gnt_o.t0)
        else $error("lone retiring thread not served");

    chk_commit_one_hot: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        commit_req_i.t0 && commit_req_i.t1 |-> (commit_gnt_o.t0 ^ commit_gnt_o.t1))
        else $error("commit selector not exclusive");

    chk_ldb_refuse_full: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        ldb_q.t0 == half_of(STA_LDB_DEPTH) && ldb_q.t1 == '0 |-> !ldb_ready_o.t0 && ldb_ready_o.t1)
        else $error("load buffer share wrong");

    chk_reset_prio_t0: assert property (@(posedge core_clk_i)
        $rose(reset_n_i) |-> !fetch_prio && !retire_prio && !commit_prio)
        else $error("thread zero not first after reset");

    chk_uopq_split: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        active_i.t0 && active_i.t1 && uopq_q.t1 >= half_of(STA_UOPQ_DEPTH) |-> !uopq_ready_o.t1)
        else $error("uop queue share exceeded");

endmodule
`default_nettype wire

//--- tb/sta_stage_model.sv
// far-side stage model: drains the partitioned queues
// assumes pops are counted by the arbiter on core_clk_i
`timescale 1ns/100ps
`default_nettype none
module sta_stage_model
    import sta_pkg::*;
(
    // clock and reset
    input  wire logic      core_clk_i,
    input  wire logic      reset_n_i,
    // control from the bench
    input  wire logic      drain_i,
    input  wire logic      slow_i,
    // pops towards the queues
    output var  sta_pair_t pop_o
);
    logic tick_q;

    // pops every cycle while drain_i is set, or every other cycle when slow
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tick_q <= 1'b0;
            pop_o  <= '0;
        end else begin
            tick_q <= ~tick_q;
            pop_o  <= (drain_i && (!slow_i || tick_q)) ? 2'b11 : 2'b00;
        end
    end
endmodule
`default_nettype wire

//--- tb/sta_arbiter_tb.sv
// self-checking bench for the two-thread pipeline arbiter
// assumes the stage model drains the queues on request
`timescale 1ns/100ps
`default_nettype none
module sta_arbiter_tb
    import sta_pkg::*;
;
    logic        core_clk, reset_n, drain, slow, en;
    sta_pair_t   act, freq, fmiss, ffill, fgnt, pop, upush, urdy, rpush, rrdy;
    sta_pair_t   lpush, lrdy, spush, srdy, bpush, brdy, retrdy, retgnt, creq, cgnt;
    sta_occ_t    uocc, bocc;
    logic [15:0] wrdy, disp;
    logic [2:0]  dcnt;
    int          bad_count, comparisons;

    always #25 core_clk = ~core_clk;

    sta_arbiter dut_u (.core_clk_i(core_clk), .reset_n_i(reset_n), .clk_en_i(en), .active_i(act),
        .fetch_req_i(freq), .fetch_miss_i(fmiss), .fetch_fill_i(ffill), .fetch_gnt_o(fgnt),
        .uopq_push_i(upush), .uopq_pop_i(pop), .uopq_ready_o(urdy), .uopq_occ_o(uocc),
        .rnq_push_i(rpush), .rnq_pop_i(pop), .rnq_ready_o(rrdy), .ldb_push_i(lpush), .ldb_pop_i(pop),
        .ldb_ready_o(lrdy), .stb_push_i(spush), .stb_pop_i(pop), .stb_ready_o(srdy),
        .wait_ready_i(wrdy), .dispatch_o(disp), .dispatch_cnt_o(dcnt), .rob_push_i(bpush),
        .rob_ready_o(brdy), .rob_occ_o(bocc), .retire_rdy_i(retrdy), .retire_gnt_o(retgnt),
        .commit_req_i(creq), .commit_gnt_o(cgnt));

    sta_stage_model model_u (.core_clk_i(core_clk), .reset_n_i(reset_n), .drain_i(drain), .slow_i(slow),
        .pop_o(pop));

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task step;
        @(posedge core_clk);
        #1;
    endtask

    task chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    // drive one selector for a cycle and judge its grant
    task sel(input int s, input sta_pair_t req, input sta_pair_t exp);
        sta_pair_t g;
        case (s)
            0: freq = req;
            1: creq = req;
            default: retrdy = req;
        endcase
        #1;
        g = (s == 0) ? fgnt : (s == 1) ? cgnt : retgnt;
        chk(16'(g), 16'(exp), "grant");
        step();
    endtask

    task push(input int q, input sta_pair_t p, input int n);
        case (q)
            0: upush = p;
            1: rpush = p;
            2: lpush = p;
            3: spush = p;
            default: bpush = p;
        endcase
        repeat (n) step();
        {upush, rpush, lpush, spush, bpush} = '0;
        step();
    endtask

    function automatic sta_pair_t rdy(input int q);
        return (q == 1) ? rrdy : (q == 2) ? lrdy : srdy;
    endfunction

    task drain_all(input logic s);
        int i;
        drain = 1'b1;
        slow = s;
        i = 0;
        while (i < 100 && !(uocc === '0 && {urdy, rrdy, lrdy, srdy} === 8'hff)) begin
            step();
            i++;
        end
        drain = 1'b0;
        chk(16'(uocc), 16'h0, "drain");
        step();
        step();
    endtask

    task dsp(input logic [15:0] w, input logic [15:0] exp, input logic [2:0] n);
        wrdy = w;
        #1;
        chk(disp, exp, "dispatch");
        chk(16'(dcnt), 16'(n), "dispatch count");
        step();
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_fetch;
        sel(0, 2'b11, 2'b10);
        sel(0, 2'b11, 2'b01);
        sel(0, 2'b11, 2'b10);
        sel(0, 2'b01, 2'b01);
        sel(0, 2'b01, 2'b01);
        sel(0, 2'b11, 2'b01);
        sel(0, 2'b00, 2'b00);
    endtask

    task t_stall;
        fmiss = 2'b10;
        sel(0, 2'b01, 2'b01);
        fmiss = '0;
        repeat (3) sel(0, 2'b11, 2'b01);
        ffill = 2'b10;
        sel(0, 2'b10, 2'b00);
        ffill = '0;
        sel(0, 2'b10, 2'b10);
        sel(0, 2'b00, 2'b00);
    endtask

    task t_commit;
        sel(1, 2'b11, 2'b10);
        sel(1, 2'b11, 2'b01);
        sel(1, 2'b10, 2'b10);
        sel(1, 2'b11, 2'b10);
        sel(1, 2'b00, 2'b00);
    endtask

    task t_reset;
        reset_n = 1'b0;
        step();
        step();
        reset_n = 1'b1;
        sel(1, 2'b11, 2'b10);
        sel(1, 2'b11, 2'b01);
    endtask

    task t_freeze;
        en = 1'b0;
        sel(1, 2'b11, 2'b10);
        sel(1, 2'b11, 2'b10);
        en = 1'b1;
        sel(1, 2'b11, 2'b10);
        sel(1, 2'b11, 2'b01);
        sel(1, 2'b00, 2'b00);
    endtask

    task t_retire;
        push(4, 2'b11, 3);
        chk(16'(bocc), 16'({6'd3, 6'd3}), "rob fill");
        sel(2, 2'b11, 2'b10);
        sel(2, 2'b11, 2'b01);
        sel(2, 2'b11, 2'b10);
        sel(2, 2'b11, 2'b01);
        sel(2, 2'b10, 2'b10);
        sel(2, 2'b11, 2'b01);
        sel(2, 2'b00, 2'b00);
        push(4, 2'b10, 20);
        chk(16'(bocc), 16'({6'd16, 6'd0}), "rob half");
        chk(16'(brdy), 16'h1, "rob ready");
        retrdy = 2'b10;
        repeat (16) step();
        retrdy = '0;
        chk(16'(bocc), 16'h0, "rob empty");
    endtask

    task t_uopq;
        push(0, 2'b11, 10);
        chk(16'(uocc), 16'({6'd8, 6'd8}), "uopq split");
        chk(16'(urdy), 16'h0, "uopq ready");
        drain_all(1'b1);
        act = 2'b10;
        push(0, 2'b10, 20);
        chk(16'(uocc), 16'({6'd16, 6'd0}), "uopq whole");
        chk(16'(urdy.t0), 16'h0, "uopq full");
        drain_all(1'b0);
        act = 2'b11;
    endtask

    task t_part;
        int lim [3];
        lim = '{8, 8, 4};
        for (int q = 1; q <= 3; q++) begin
            push(q, 2'b10, lim[q-1] - 1);
            chk(16'(rdy(q)), 16'h3, "part room");
            push(q, 2'b10, 1);
            chk(16'(rdy(q)), 16'h1, "part full");
        end
        drain_all(1'b1);
    endtask

    task t_disp;
        dsp(16'hffff, 16'h003f, 3'd6);
        dsp(16'h7f00, 16'h3f00, 3'd6);
        dsp(16'h8421, 16'h8421, 3'd4);
        dsp(16'h0000, 16'h0000, 3'd0);
    endtask

    task test_done;
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        #(50 * 2000);
        bad_count++;
        $display("BAD %0t watchdog expired", $time);
        test_done();
    end

    initial begin
        core_clk = 1'b0;
        reset_n = 1'b0;
        drain = 1'b0;
        slow = 1'b0;
        en = 1'b1;
        act = 2'b11;
        {freq, fmiss, ffill, upush, rpush, lpush, spush, bpush, retrdy, creq} = '0;
        wrdy = '0;
        bad_count = 0;
        comparisons = 0;
        repeat (8) @(posedge core_clk);
        #1 reset_n = 1'b1;
        step();
        t_fetch();
        t_stall();
        t_commit();
        t_reset();
        t_freeze();
        t_retire();
        t_uopq();
        t_part();
        t_disp();
        test_done();
    end
endmodule
`default_nettype wire
